// ==== hw/rtcic_params.svh ====
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Word-indexed registers, byte address is four times the index
// Notes:   Definitions only
`ifndef RTCIC_PARAMS_SVH
`define RTCIC_PARAMS_SVH

// ===========================================================================
// Register indices
`define RTCIC_IDX_CONTROL_1     6'h00
`define RTCIC_IDX_IRQ_ENABLE    6'h01
`define RTCIC_IDX_IRQ_FLAGS     6'h02
`define RTCIC_IDX_STATUS        6'h03
`define RTCIC_IDX_NV_CONTROL    6'h30

// ===========================================================================
// Field positions
`define RTCIC_BIT_WATCH_EN      0
`define RTCIC_BIT_RECOVERY_EN   4
`define RTCIC_BIT_CLK_INT       7
`define RTCIC_BIT_SCAN_SEL      0
`define RTCIC_BIT_CLK_SEL_LO    2
`define RTCIC_BIT_CLK_SEL_HI    3
`define RTCIC_BIT_PIN_LEVEL     7
`define RTCIC_NUM_SRC           5

// ===========================================================================
// Reset values
`define RTCIC_RST_CONTROL_1     8'h11
`define RTCIC_RST_IRQ_ENABLE    8'h00
`define RTCIC_RST_IRQ_FLAGS     8'h00
`define RTCIC_RST_STATUS        8'h00
`define RTCIC_RST_NV_CONTROL    8'h00

// ===========================================================================
// Timing
`define RTCIC_CLK_HZ            20000000
`define RTCIC_PWRUP_MS          70
`define RTCIC_PWRUP_CYC         ((`RTCIC_PWRUP_MS * `RTCIC_CLK_HZ) / 1000)
`define RTCIC_SCAN_SHORT_S      1
`define RTCIC_SCAN_LONG_S       16
`define RTCIC_TIMEOUT_SHORT     6'(2 * `RTCIC_SCAN_SHORT_S)
`define RTCIC_TIMEOUT_LONG      6'(2 * `RTCIC_SCAN_LONG_S)

`endif

// ==== hw/rtcic_pkg.sv ====
// Purpose: Shared types of the interrupt and clock output block
// Assumes: Constants live in rtcic_params.svh
// Notes:   Types only
package rtcic_pkg;

  // =========================================================================
  // Clock output selection
  typedef enum logic [1:0] {
    RTCIC_F32768,
    RTCIC_F1024,
    RTCIC_F32,
    RTCIC_F1
  } rtcic_clk_sel_t;

  typedef logic [7:0] rtcic_byte_t;

endpackage

// ==== hw/rtcic_pre_if.sv ====
// Purpose: Carrier between control logic and prescaler
// Assumes: One clock domain
// Notes:   ctrl drives oscillator edges and compensation
`timescale 1ns/100ps

interface rtcic_pre_if;
  logic osc_rise;
  logic comp_add;
  logic comp_sub;
  logic div_1024;
  logic div_32;
  logic div_1;
  logic tick_1hz;

  modport ctrl (
    output osc_rise,
    output comp_add,
    output comp_sub,
    input  div_1024,
    input  div_32,
    input  div_1,
    input  tick_1hz
  );

  modport pre (
    input  osc_rise,
    input  comp_add,
    input  comp_sub,
    output div_1024,
    output div_32,
    output div_1,
    output tick_1hz
  );
endinterface

// ==== hw/rtcic_prescaler.sv ====
// Purpose: Divides oscillator edges to 1024, 32 and 1 Hz
// Assumes: osc_rise is a one-cycle pulse per oscillator period
// Notes:   Compensation adds or swallows one count
`timescale 1ns/100ps
`include "rtcic_params.svh"

module rtcic_prescaler (
  input  wire logic clk,
  input  wire logic sys_rst,
  rtcic_pre_if.pre  pre
);

  logic [14:0] count;
  logic [14:0] next_count;
  logic        tick;

  // ===========================================================================
  // Counter
  // Divider taps are plain counter bits, so high and low times match
  always_comb
  begin
    next_count = count;
    if (pre.osc_rise && !pre.comp_sub)
    begin
      next_count = count + 15'h0001;
    end
    if (pre.comp_add)
    begin
      next_count = next_count + 15'h0001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      count <= 15'h0000;
      tick  <= 1'b0;
    end
    else
    begin
      count <= next_count;
      tick  <= count[14] && !next_count[14];
    end
  end

  // ===========================================================================
  // Taps
  assign pre.div_1024 = count[4];
  assign pre.div_32   = count[9];
  assign pre.div_1    = count[14];
  assign pre.tick_1hz = tick;

endmodule // rtcic_prescaler

// ==== hw/rtcic_top.sv ====
// Purpose: Interrupt pin, watch enable, self-recovery and clock output
// Assumes: Avalon-MM slave with waitrequest, one 20 MHz clock
// Notes:   Oscillator and pins are synchronised before use
//
// Overview of operation
// - Five sources latch request flags in bits 0 to 4 of the flag register; bits 0 to 3 latch only while their enable bit is set.
// - Interrupt pin is active low open drain, only ever pulled low.
// - Alarm enable bit 0 lets the pin follow alarm flag; zero write clears.
// - Timer enable bit 1 lets the pin follow timer flag; zero write clears.
// - Low-voltage one flag releases only once flag and status bit 2 clear.
// - Low-voltage two flag releases only once flag and status bit 3 clear.
// - System-reset flag releases only once flag and status bit 4 clear.
// - Watch enable bit 0 gates the 1 Hz time base, reset value one.
// - Watch enable zero holds the time counters; one restarts them.
// - Watch enable never touches the clock output.
// - Supervision counter not cleared in time forces a recovery reset.
// - Recovery enable bit 4 switches supervision, reset value one.
// - Recovery reloads control registers; time, alarm, timer kept.
// - After a recovery reset the reset flag bit 4 is set.
// - Select bits 3 to 2 pick 32768, 1024, 32 or 1 Hz.
// - 32768 Hz is raw oscillator; lower rates carry compensation.
// - Prescaler rates have equal high and low times.
// - After power-up the output runs at 32768 Hz for about 70 ms.
// - Clock/int bit 7 makes the pin push-pull, gated by the gate pin.
// - Recovery timeout scales with the scan period select.
// - Scan select zero means one second, one means sixteen seconds.
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/100ps
`include "rtcic_params.svh"

module rtcic_top #(
  parameter int PWRUP_CYC = `RTCIC_PWRUP_CYC
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        osc_32k,
  input  wire logic        alarm_event,
  input  wire logic        timer_event,
  input  wire logic        low_voltage_one,
  input  wire logic        low_voltage_two,
  input  wire logic        supervise_kick,
  input  wire logic        comp_add,
  input  wire logic        comp_sub,
  input  wire logic        irq_pin_i,
  output logic             irq_pin_o,
  output logic             irq_pin_oe,
  input  wire logic        clock_out_gate,
  output logic             clock_out_pin,
  output logic             clock_out_oe,
  output logic             watch_tick,
  output logic             recovery_rst
);

  // ===========================================================================
  // Declarations
  rtcic_pkg::rtcic_byte_t control_1;
  rtcic_pkg::rtcic_byte_t irq_enable;
  rtcic_pkg::rtcic_byte_t interrupt_flags;
  rtcic_pkg::rtcic_byte_t control_status;
  rtcic_pkg::rtcic_byte_t nonvolatile_control;
  rtcic_pkg::rtcic_clk_sel_t clk_sel;

  logic [2:0]  sync_1;
  logic [2:0]  sync_2;
  logic        osc_prev;
  logic        osc_rise;
  logic        bus_hit;
  logic        wr_lo;
  logic [5:0]  wr_idx;
  logic [5:0]  sup_count;
  logic [5:0]  sup_limit;
  logic        recover;
  logic [20:0] pwrup_count;
  logic        pwrup_hold;
  logic        sel_clock;
  logic [4:0]  src_event;
  logic [4:0]  flag_clear;
  logic [4:0]  next_flags;
  logic [4:0]  status_clear;
  logic [4:0]  next_status;

  rtcic_pre_if pre_bus ();

  // ===========================================================================
  // Address decode
  function automatic logic is_idx(input logic [7:0] addr,
                                  input logic [5:0] idx);
    is_idx = (addr[7:2] == idx) && (addr[1:0] == 2'h0);
  endfunction

  // ===========================================================================
  // Pin synchronisers
  // Stage one feeds stage two only, never logic
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sync_1 <= 3'h0;
      sync_2 <= 3'h0;
    end
    else
    begin
      sync_1 <= {irq_pin_i, clock_out_gate, osc_32k};
      sync_2 <= sync_1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      osc_prev <= 1'b0;
    end
    else
    begin
      osc_prev <= sync_2[0];
    end
  end

  assign osc_rise = sync_2[0] && !osc_prev;

  // ===========================================================================
  // Prescaler
  assign pre_bus.osc_rise = osc_rise;
  assign pre_bus.comp_add = comp_add;
  assign pre_bus.comp_sub = comp_sub;

  rtcic_prescaler u_prescaler (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pre     (pre_bus.pre)
  );

  // ===========================================================================
  // Avalon slave
  // One wait cycle per access; write acts on the edge waitrequest is low
  assign bus_hit = (read || write) && !waitrequest;
  assign wr_lo   = write && !waitrequest && byteenable[0];
  assign wr_idx  = address[7:2];

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      waitrequest <= 1'b1;
    end
    else
    begin
      waitrequest <= !((read || write) && waitrequest);
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      readdata <= 32'h0000_0000;
    end
    else if (read && waitrequest)
    begin
      readdata <= 32'h0000_0000;
      if (is_idx(address, `RTCIC_IDX_CONTROL_1))
      begin
        readdata[7:0] <= control_1;
      end
      if (is_idx(address, `RTCIC_IDX_IRQ_ENABLE))
      begin
        readdata[7:0] <= irq_enable;
      end
      if (is_idx(address, `RTCIC_IDX_IRQ_FLAGS))
      begin
        readdata[7:0] <= interrupt_flags;
      end
      if (is_idx(address, `RTCIC_IDX_STATUS))
      begin
        readdata[7:0] <= control_status;
        readdata[`RTCIC_BIT_PIN_LEVEL] <= sync_2[2];
      end
      if (is_idx(address, `RTCIC_IDX_NV_CONTROL))
      begin
        readdata[7:0] <= nonvolatile_control;
      end
    end
  end

  // ===========================================================================
  // Control registers
  // Recovery reloads these but leaves the nonvolatile register alone
  always_ff @(posedge clk)
  begin
    if (sys_rst || recover)
    begin
      control_1  <= `RTCIC_RST_CONTROL_1;
      irq_enable <= `RTCIC_RST_IRQ_ENABLE;
    end
    else if (wr_lo && bus_hit)
    begin
      if (wr_idx == `RTCIC_IDX_CONTROL_1 && address[1:0] == 2'h0)
      begin
        control_1 <= writedata[7:0] & 8'h91;
      end
      if (wr_idx == `RTCIC_IDX_IRQ_ENABLE && address[1:0] == 2'h0)
      begin
        irq_enable <= writedata[7:0] & 8'h1F;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      nonvolatile_control <= `RTCIC_RST_NV_CONTROL;
    end
    else if (wr_lo && is_idx(address, `RTCIC_IDX_NV_CONTROL))
    begin
      nonvolatile_control <= writedata[7:0];
    end
  end

  // ===========================================================================
  // Flags and status
  assign src_event = {recover,
                      low_voltage_two,
                      low_voltage_one,
                      timer_event,
                      alarm_event};

  // Low-voltage and reset flags stay put until their status bit is zero
  genvar g;
  generate
    for (g = 0; g < `RTCIC_NUM_SRC; g = g + 1)
    begin : g_flag
      if (g < 2)
      begin : g_simple
        assign flag_clear[g] = wr_lo &&
          is_idx(address, `RTCIC_IDX_IRQ_FLAGS) &&
          !writedata[g];
        assign status_clear[g] = 1'b0;
        assign next_status[g]  = 1'b0;
      end
      else
      begin : g_paired
        assign flag_clear[g] = wr_lo &&
          is_idx(address, `RTCIC_IDX_IRQ_FLAGS) &&
          !writedata[g] && !control_status[g];
        assign status_clear[g] = wr_lo &&
          is_idx(address, `RTCIC_IDX_STATUS) && !writedata[g];
        // Set wins over a clear in the same cycle
        assign next_status[g] = src_event[g] ||
          (control_status[g] && !status_clear[g]);
      end
      assign next_flags[g] = (src_event[g] && (irq_enable[g] || g == 4)) ||
        (interrupt_flags[g] && !flag_clear[g]);
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      interrupt_flags <= `RTCIC_RST_IRQ_FLAGS;
      control_status  <= `RTCIC_RST_STATUS;
    end
    else if (recover)
    begin
      interrupt_flags <= `RTCIC_RST_IRQ_FLAGS | 8'h10;
      control_status  <= `RTCIC_RST_STATUS | 8'h10;
    end
    else
    begin
      interrupt_flags <= {3'h0, next_flags};
      control_status  <= {3'h0, next_status};
    end
  end

  // ===========================================================================
  // Interrupt pin
  // Output value never rises: the pull-up gives the idle level
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      irq_pin_o  <= 1'b0;
      irq_pin_oe <= 1'b0;
    end
    else
    begin
      irq_pin_o  <= 1'b0;
      irq_pin_oe <= |(irq_enable[4:0] & next_flags);
    end
  end

  // ===========================================================================
  // Watch time base
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      watch_tick <= 1'b0;
    end
    else
    begin
      watch_tick <= pre_bus.tick_1hz &&
                    control_1[`RTCIC_BIT_WATCH_EN];
    end
  end

  // ===========================================================================
  // Self-recovery supervision
  // Counts whole seconds, so timeout resolution is one second
  assign sup_limit = nonvolatile_control[`RTCIC_BIT_SCAN_SEL] ?
                     `RTCIC_TIMEOUT_LONG :
                     `RTCIC_TIMEOUT_SHORT;
  assign recover   = control_1[`RTCIC_BIT_RECOVERY_EN] &&
                     pre_bus.tick_1hz && !supervise_kick &&
                     (sup_count == sup_limit - 6'h01);

  always_ff @(posedge clk)
  begin
    if (sys_rst || recover || supervise_kick ||
        !control_1[`RTCIC_BIT_RECOVERY_EN])
    begin
      sup_count <= 6'h00;
    end
    else if (pre_bus.tick_1hz)
    begin
      sup_count <= sup_count + 6'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      recovery_rst <= 1'b0;
    end
    else
    begin
      recovery_rst <= recover;
    end
  end

  // ===========================================================================
  // Power-up hold
  // Only power-up, not recovery, restarts the hold
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pwrup_count <= 21'h000000;
      pwrup_hold  <= 1'b1;
    end
    else if (pwrup_hold)
    begin
      pwrup_count <= pwrup_count + 21'h000001;
      pwrup_hold  <= (pwrup_count < 21'(PWRUP_CYC - 1));
    end
  end

  // ===========================================================================
  // Clock output
  assign clk_sel = pwrup_hold ? rtcic_pkg::RTCIC_F32768 :
    rtcic_pkg::rtcic_clk_sel_t'(nonvolatile_control[3:2]);

  always_comb
  begin
    unique case (clk_sel)
      rtcic_pkg::RTCIC_F32768: sel_clock = sync_2[0];
      rtcic_pkg::RTCIC_F1024:  sel_clock = pre_bus.div_1024;
      rtcic_pkg::RTCIC_F32:    sel_clock = pre_bus.div_32;
      rtcic_pkg::RTCIC_F1:     sel_clock = pre_bus.div_1;
    endcase
  end

  // Watch enable deliberately absent here
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      clock_out_pin <= 1'b0;
      clock_out_oe  <= 1'b0;
    end
    else
    begin
      clock_out_oe  <= control_1[`RTCIC_BIT_CLK_INT];
      clock_out_pin <= sel_clock && sync_2[1];
    end
  end

endmodule // rtcic_top

// ==== verif/rtcic_host_model.sv ====
// Purpose: Host side of the interrupt and clock pins
// Assumes: Pull-up on the interrupt wire
// Notes:   Measures clock output high and low times
`timescale 1ns/100ps

module rtcic_host_model (
  input  wire logic clk,
  input  wire logic irq_pin_o,
  input  wire logic irq_pin_oe,
  output logic      irq_pin_i,
  input  wire logic gate_req,
  output logic      clock_out_gate,
  input  wire logic clock_out_pin,
  output int        hi_len,
  output int        lo_len
);
  int   run;
  logic last;

  // ==========================================================================
  // Pins
  // Pull-up gives the idle level; only the device pulls low
  assign irq_pin_i = irq_pin_oe ? irq_pin_o : 1'b1;
  // Host holds the gate steady between requests
  assign clock_out_gate = gate_req;

  // ==========================================================================
  // Run lengths of the clock output
  initial
  begin
    run = 0;
    last = 1'b0;
    hi_len = 0;
    lo_len = 0;
  end

  always @(posedge clk)
  begin
    if (clock_out_pin !== last)
    begin
      if (last)
        hi_len <= run;
      else
        lo_len <= run;
      run <= 1;
    end
    else
      run <= run + 1;
    last <= clock_out_pin;
  end
endmodule // rtcic_host_model

// ==== verif/rtcic_top_assertions.sv ====
// Purpose: Port checks of rtcic_top
// Assumes: Enable register at byte address 04
// Notes:   Bound to the top module below
`timescale 1ns/100ps

module rtcic_top_assertions (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] writedata,
  input wire logic        waitrequest,
  input wire logic        alarm_event,
  input wire logic        timer_event,
  input wire logic        low_voltage_one,
  input wire logic        low_voltage_two,
  input wire logic        irq_pin_o,
  input wire logic        irq_pin_oe,
  input wire logic        clock_out_gate,
  input wire logic        clock_out_pin,
  input wire logic        clock_out_oe,
  input wire logic        recovery_rst
);
  logic [4:0] en;
  logic       take;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ==========================================================================
  // Shadow of the enables; lags a recovery reload by a cycle
  assign take = write && !waitrequest && byteenable[0];
  always_ff @(posedge clk)
  begin
    if (sys_rst || recovery_rst)
      en <= 5'h00;
    else if (take && address == 8'h04)
      en <= writedata[4:0];
  end

  // ==========================================================================
  // Properties
  a_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("wait low too long");
  a_wait_answer: assert property ((read || write) && waitrequest
    |=> !waitrequest)
    else $error("no answer");
  a_irq_pull_only: assert property (!irq_pin_o)
    else $error("pin driven high");
  a_irq_raise: assert property (|({low_voltage_two, low_voltage_one,
    timer_event, alarm_event} & en[3:0]) |=> irq_pin_oe)
    else $error("pin not pulled");
  a_irq_quiet: assert property (en == 5'h00 && $past(en) == 5'h00
    |-> !irq_pin_oe)
    else $error("pin pulled with no enable");
  a_clk_oe_ctrl: assert property (take && address == 8'h00
    |=> ##1 clock_out_oe == $past(writedata[7], 2))
    else $error("clock oe wrong");
  a_gate_low: assert property (!clock_out_gate [*6] |-> !clock_out_pin)
    else $error("gated clock high");
  a_rst_idle: assert property ($fell(sys_rst)
    |-> waitrequest && !irq_pin_oe && !clock_out_oe)
    else $error("not idle after reset");
endmodule // rtcic_top_assertions

bind rtcic_top rtcic_top_assertions u_chk (
  .clk, .sys_rst, .address, .read, .write, .byteenable, .writedata,
  .waitrequest, .alarm_event, .timer_event, .low_voltage_one,
  .low_voltage_two, .irq_pin_o, .irq_pin_oe, .clock_out_gate,
  .clock_out_pin, .clock_out_oe, .recovery_rst
);

// ==== verif/rtcic_top_test.sv ====
// Purpose: Self-checking bench of rtcic_top
// Assumes: Oscillator sped up to one period per 4 clocks
// Notes:   Held prescaler add brings the 1 Hz paths into reach
`timescale 1ns/100ps

module rtcic_top_test;
  localparam int LIMIT = 80000;
  logic        clk;
  logic        sys_rst;
  logic [7:0]  address;
  logic        read;
  logic        write;
  logic [3:0]  byteenable;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [1:0]  osc_div;
  logic [3:0]  evs;
  logic        gate_req;
  logic        irq_pin_i;
  logic        irq_pin_o;
  logic        irq_pin_oe;
  logic        clock_out_gate;
  logic        clock_out_pin;
  logic        clock_out_oe;
  logic        comp_hold;
  logic        watch_tick;
  logic        recovery_rst;
  int          n_tick;
  int          n_rec;
  int          hi_len;
  int          lo_len;
  int          err_total;
  int          n_tests;
  int          cyc;
  logic [31:0] rng;

  rtcic_top #(.PWRUP_CYC(20)) i_dut (
    .clk, .sys_rst, .address, .read, .write, .byteenable, .writedata,
    .readdata, .waitrequest, .osc_32k(osc_div[1]),
    .alarm_event(evs[0]), .timer_event(evs[1]),
    .low_voltage_one(evs[2]), .low_voltage_two(evs[3]),
    .supervise_kick(1'b0), .comp_add(comp_hold), .comp_sub(1'b0),
    .irq_pin_i, .irq_pin_o, .irq_pin_oe, .clock_out_gate, .clock_out_pin,
    .clock_out_oe, .watch_tick, .recovery_rst
  );

  rtcic_host_model i_host (
    .clk, .irq_pin_o, .irq_pin_oe, .irq_pin_i, .gate_req, .clock_out_gate,
    .clock_out_pin, .hi_len, .lo_len
  );

  // ==========================================================================
  // Clock, oscillator and timeout
  always #25 clk = ~clk;

  always @(posedge clk)
  begin
    osc_div <= osc_div + 2'h1;
    cyc <= cyc + 1;
    n_tick <= n_tick + int'(watch_tick);
    n_rec <= n_rec + int'(recovery_rst);
    if (cyc == LIMIT)
    begin
      err_total++;
      end_of_test();
    end
  end

  // ==========================================================================
  // Expectations and checks
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Half period in clocks for every select, raw 32768 Hz included; no compensation driven
  function automatic int half_of(input logic [1:0] c);
    return 2 << (5 * c);
  endfunction

  task automatic chk_reg(input string n, input logic [7:0] e,
                         input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask

  task automatic chk_cnt(input string n, input int e, input int g);
    n_tests++;
    if (g != e)
    begin
      $display("wrong value %s expected %0d seen %0d", n, e, g);
      err_total++;
    end
  endtask

  // ==========================================================================
  // Bus and pin tasks
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [7:0] wd, input logic [3:0] be,
                     output logic [7:0] rd);
    address <= a;
    writedata <= {24'h000000, wd};
    byteenable <= be;
    read <= !wr;
    write <= wr;
    @(posedge clk);
    while (waitrequest !== 1'b0)
      @(posedge clk);
    rd = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    bus(1'b1, a, d, 4'h1, v);
  endtask

  task automatic rd(input string n, input logic [7:0] a,
                    input logic [7:0] e);
    logic [7:0] d;
    bus(1'b0, a, 8'h00, 4'hF, d);
    chk_reg(n, e, d);
  endtask

  // Outputs are looked at mid-cycle, after the edge's updates
  task automatic pin(input string n, input int w, input logic e);
    logic g;
    @(negedge clk);
    g = (w == 0) ? irq_pin_oe : (w == 1) ? clock_out_pin : clock_out_oe;
    chk_reg(n, {7'h00, e}, {7'h00, g});
    @(posedge clk);
  endtask

  task automatic pulse(input int i);
    evs[i] <= 1'b1;
    @(posedge clk);
    evs <= 4'h0;
    @(posedge clk);
  endtask

  task automatic rst_chk();
    pin("oe reset", 0, 1'b0);
    rd("control", 8'h00, 8'h11);
    rd("enables", 8'h04, 8'h00);
    rd("flags", 8'h08, 8'h00);
    rd("status", 8'h0C, 8'h80);
    rd("nv", 8'hC0, 8'h00);
    rd("misaligned", 8'h01, 8'h00);
    $display("test reset done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    logic [7:0] v;
    logic [7:0] m;
    int         s;
    int         i;
    clk = 1'b0;
    sys_rst = 1'b1;
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'h0;
    writedata = 32'h00000000;
    osc_div = 2'h0;
    evs = 4'h0;
    gate_req = 1'b1;
    err_total = 0;
    n_tests = 0;
    cyc = 0;
    comp_hold = 1'b0;
    n_tick = 0;
    n_rec = 0;
    rng = 32'hE23BDF41;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rst_chk();
    rng = xs(rng);
    s = rng[1:0];
    for (int k = 0; k < 4; k++)
    begin
      i = (k + s) % 4;
      m = 8'h01 << i;
      wr(8'h04, m);
      pulse(i);
      pin("irq set", 0, 1'b1);
      rd("flag set", 8'h08, m);
      rd("status set", 8'h0C, (i > 1) ? m : 8'h00);
      wr(8'h08, 8'hFF);
      if (i > 1)
      begin
        wr(8'h08, 8'h00);
        pin("irq held", 0, 1'b1);
        wr(8'h0C, 8'h00);
      end
      wr(8'h08, 8'h00);
      pin("irq clear", 0, 1'b0);
      wr(8'h04, 8'h00);
      rd("pin level", 8'h0C, 8'h80);
    end
    pulse(0);
    pulse(2);
    pin("irq masked", 0, 1'b0);
    rd("flags masked", 8'h08, 8'h00);
    rd("status masked", 8'h0C, 8'h84);
    wr(8'h0C, 8'h00);
    $display("test interrupt done");
    rng = xs(rng);
    wr(8'h00, rng[7:0]);
    rd("control rw", 8'h00, rng[7:0] & 8'h91);
    wr(8'hC0, rng[15:8]);
    bus(1'b1, 8'hC0, ~rng[15:8], 4'h0, v);
    rd("nv rw", 8'hC0, rng[15:8]);
    wr(8'h40, 8'h5A);
    rd("unmapped", 8'h40, 8'h00);
    $display("test registers done");
    // Watch enable alternates, one setting per rate, over the 32768, 1024 and 32 Hz runs
    for (int c = 0; c < 3; c++)
    begin
      wr(8'h00, 8'h80 | 8'(c % 2));
      wr(8'hC0, 8'(c << 2));
      repeat (6 * half_of(2'(c)) + 40) @(posedge clk);
      chk_cnt("high time", half_of(2'(c)), hi_len);
      chk_cnt("low time", half_of(2'(c)), lo_len);
    end
    pin("clock oe", 2, 1'b1);
    gate_req <= 1'b0;
    repeat (8) @(posedge clk);
    pin("clock gated", 1, 1'b0);
    gate_req <= 1'b1;
    $display("test clock output done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rst_chk();
    // Held add speeds the prescaler so two seconds fit in the run
    wr(8'h00, 8'h91);
    wr(8'h04, 8'h1F);
    comp_hold <= 1'b1;
    while (n_rec == 0)
      @(posedge clk);
    comp_hold <= 1'b0;
    chk_cnt("watch ticks", 2, n_tick);
    chk_cnt("recoveries", 1, n_rec);
    rd("control reload", 8'h00, 8'h11);
    rd("enables reload", 8'h04, 8'h00);
    rd("flags recovery", 8'h08, 8'h10);
    rd("status recovery", 8'h0C, 8'h90);
    $display("test recovery done");
    end_of_test();
  end
endmodule // rtcic_top_test
